// ---- design/slcc_top.v ----
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "slcc_defines.vh"

module slcc_top #(
    parameter LANE_W = 40,
    parameter SAMPLE_W = 16,
    parameter ADDR_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Lane receiver
    input wire [LANE_W-1:0] lane_data,
    input wire lane_bit_error,
    // Deframed samples
    input wire sample_valid,
    input wire [SAMPLE_W-1:0] sample_data,
    input wire [3:0] sample_index,
    input wire [1:0] sample_subchannel,
    input wire sample_link,
    input wire sample_q,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Interrupt
    output reg irq
);

    reg rst_meta_r;
    reg rst_sync_r;
    wire rst_n;

    // Reset released through two flops
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    reg [7:0] cap_ctrl_r;
    reg [7:0] chk_ctrl_r;
    reg [7:0] ref_low_r;
    reg [7:0] ref_high_r;
    reg [7:0] chk_sel_r;
    reg [1:0] irq_stat_r;
    reg [1:0] irq_mask_r;
    reg [LANE_W-1:0] cap_word_r;
    reg req_prev_r;
    reg fail_r;

    reg aw_hold_r;
    reg w_hold_r;
    reg [ADDR_W-1:0] waddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    function is_mapped;
        input [9:0] idx;
        begin
            case (idx)
                `SLCC_IDX_CAP_CTRL, `SLCC_IDX_CAP_B0, `SLCC_IDX_CAP_B1,
                `SLCC_IDX_CAP_B2, `SLCC_IDX_CAP_B3, `SLCC_IDX_CAP_B4,
                `SLCC_IDX_CHK_CTRL, `SLCC_IDX_REF_LOW, `SLCC_IDX_REF_HIGH,
                `SLCC_IDX_CHK_SEL, `SLCC_IDX_IRQ_STAT, `SLCC_IDX_IRQ_MASK: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // Index taken from a byte address; the low two address bits are ignored
    function [9:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[11:2];
        end
    endfunction

    // Response code for an access to the given index
    function [1:0] resp_for;
        input [9:0] idx;
        begin
            resp_for = is_mapped(idx) ? `SLCC_RESP_OKAY : `SLCC_RESP_SLVERR;
        end
    endfunction

    // Byte n of the held capture word, lowest byte first
    function [7:0] cap_byte;
        input [LANE_W-1:0] src;
        input [2:0] n;
        begin
            cap_byte = src[n*8 +: 8];
        end
    endfunction

    // Registers are one byte wide; upper read bits are zero
    function [31:0] pad_byte;
        input [7:0] b;
        begin
            pad_byte = {24'h00_0000, b};
        end
    endfunction

    wire [9:0] widx = reg_index(waddr_r);
    wire [9:0] ridx = reg_index(s_axi_araddr);
    wire do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
    wire wr_hit = do_write && wstrb_r[0] && is_mapped(widx);
    wire [7:0] wbyte = wdata_r[7:0];
    wire do_read = s_axi_arvalid && s_axi_arready;

    // Capture trigger
    wire req_rise = cap_ctrl_r[`SLCC_CAP_REQ_BIT] && !req_prev_r;
    wire cap_trig = cap_ctrl_r[`SLCC_CAP_MODE_BIT] ? lane_bit_error : req_rise;

    // Sample check
    wire [SAMPLE_W-1:0] ref_word = {ref_high_r, ref_low_r};
    wire sel_hit = sample_valid
        && sample_index == chk_ctrl_r[`SLCC_CHK_SP_HI:`SLCC_CHK_SP_LO]
        && sample_subchannel == chk_ctrl_r[`SLCC_CHK_CHAN_HI:`SLCC_CHK_CHAN_LO]
        && sample_link == chk_sel_r[`SLCC_SEL_LINK_BIT]
        && sample_q == chk_sel_r[`SLCC_SEL_IQ_BIT];
    wire chk_clear = chk_ctrl_r[`SLCC_CHK_CLR_BIT];
    // Held clear overrides compare so a stale mismatch cannot reappear
    wire mismatch = chk_ctrl_r[`SLCC_CHK_EN_BIT] && !chk_clear
        && sel_hit && sample_data != ref_word;

    wire [1:0] irq_set = {mismatch, cap_trig};
    wire stat_wr = wr_hit && widx == `SLCC_IDX_IRQ_STAT;
    // Writable fields of the narrow registers
    wire [1:0] cap_field = wbyte[`SLCC_CAP_MODE_BIT:`SLCC_CAP_REQ_BIT];
    wire [1:0] sel_field = wbyte[`SLCC_SEL_LINK_BIT:`SLCC_SEL_IQ_BIT];
    wire [1:0] irq_field = wbyte[`SLCC_IRQ_FAIL_BIT:`SLCC_IRQ_CAP_BIT];

    // Capture bytes and the fail flag are read-only, so writes to them land nowhere
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_ctrl_r <= `SLCC_RST_BYTE;
            chk_ctrl_r <= `SLCC_RST_BYTE;
            ref_low_r <= `SLCC_RST_BYTE;
            ref_high_r <= `SLCC_RST_BYTE;
            chk_sel_r <= `SLCC_RST_BYTE;
            irq_mask_r <= `SLCC_RST_IRQ;
        end else if (wr_hit) begin
            case (widx)
                `SLCC_IDX_CAP_CTRL: cap_ctrl_r <= {6'h00, cap_field};
                `SLCC_IDX_CHK_CTRL: chk_ctrl_r <= wbyte;
                `SLCC_IDX_REF_LOW: ref_low_r <= wbyte;
                `SLCC_IDX_REF_HIGH: ref_high_r <= wbyte;
                `SLCC_IDX_CHK_SEL: chk_sel_r <= {sel_field, 6'h00};
                `SLCC_IDX_IRQ_MASK: irq_mask_r <= irq_field;
                default: cap_ctrl_r <= cap_ctrl_r;
            endcase
        end
    end

    // Request bit stays set; software writes 0 then 1 to capture again
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_prev_r <= 1'b0;
            cap_word_r <= `SLCC_RST_WORD;
        end else begin
            req_prev_r <= cap_ctrl_r[`SLCC_CAP_REQ_BIT];
            if (cap_trig) begin
                cap_word_r <= lane_data;
            end
        end
    end

    // Sticky result of the sample check
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_r <= 1'b0;
        end else if (chk_clear) begin
            fail_r <= 1'b0;
        end else if (mismatch) begin
            fail_r <= 1'b1;
        end
    end

    // A new event wins over a write-one clear; irq trails a clear or mask write by one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= `SLCC_RST_IRQ;
            irq <= 1'b0;
        end else begin
            if (stat_wr) begin
                irq_stat_r <= (irq_stat_r & ~irq_field) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            irq <= |((irq_stat_r | irq_set) & irq_mask_r);
        end
    end

    // Write channels: address and data taken in either order
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            waddr_r <= {ADDR_W{1'b0}};
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SLCC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                waddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (do_write) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= resp_for(widx);
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read in flight
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SLCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !do_read;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= resp_for(ridx);
                case (ridx)
                    `SLCC_IDX_CAP_CTRL: s_axi_rdata <= pad_byte(cap_ctrl_r);
                    `SLCC_IDX_CAP_B0: s_axi_rdata <= pad_byte(cap_byte(cap_word_r, 3'h0));
                    `SLCC_IDX_CAP_B1: s_axi_rdata <= pad_byte(cap_byte(cap_word_r, 3'h1));
                    `SLCC_IDX_CAP_B2: s_axi_rdata <= pad_byte(cap_byte(cap_word_r, 3'h2));
                    `SLCC_IDX_CAP_B3: s_axi_rdata <= pad_byte(cap_byte(cap_word_r, 3'h3));
                    `SLCC_IDX_CAP_B4: s_axi_rdata <= pad_byte(cap_byte(cap_word_r, 3'h4));
                    `SLCC_IDX_CHK_CTRL: s_axi_rdata <= pad_byte(chk_ctrl_r);
                    `SLCC_IDX_REF_LOW: s_axi_rdata <= pad_byte(ref_low_r);
                    `SLCC_IDX_REF_HIGH: s_axi_rdata <= pad_byte(ref_high_r);
                    `SLCC_IDX_CHK_SEL: s_axi_rdata <= pad_byte({chk_sel_r[7:1], fail_r});
                    `SLCC_IDX_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat_r};
                    `SLCC_IDX_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask_r};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- common/slcc_defines.vh ----
`ifndef SLCC_DEFINES_VH
`define SLCC_DEFINES_VH

// Register indexes; byte address is four times the index
`define SLCC_IDX_CAP_CTRL 10'h31E
`define SLCC_IDX_CAP_B0 10'h31F
`define SLCC_IDX_CAP_B1 10'h320
`define SLCC_IDX_CAP_B2 10'h321
`define SLCC_IDX_CAP_B3 10'h322
`define SLCC_IDX_CAP_B4 10'h323
`define SLCC_IDX_CHK_CTRL 10'h32C
`define SLCC_IDX_REF_LOW 10'h32D
`define SLCC_IDX_REF_HIGH 10'h32E
`define SLCC_IDX_CHK_SEL 10'h32F
`define SLCC_IDX_IRQ_STAT 10'h340
`define SLCC_IDX_IRQ_MASK 10'h341

// Capture control fields
`define SLCC_CAP_REQ_BIT 0
`define SLCC_CAP_MODE_BIT 1

// Check control fields
`define SLCC_CHK_EN_BIT 0
`define SLCC_CHK_CLR_BIT 1
`define SLCC_CHK_CHAN_HI 3
`define SLCC_CHK_CHAN_LO 2
`define SLCC_CHK_SP_HI 7
`define SLCC_CHK_SP_LO 4

// Check select / status fields
`define SLCC_SEL_FAIL_BIT 0
`define SLCC_SEL_IQ_BIT 6
`define SLCC_SEL_LINK_BIT 7

// Interrupt status bits
`define SLCC_IRQ_CAP_BIT 0
`define SLCC_IRQ_FAIL_BIT 1

// Reset values
`define SLCC_RST_BYTE 8'h00
`define SLCC_RST_WORD 40'h00_0000_0000
`define SLCC_RST_IRQ 2'h0

// Bus answers
`define SLCC_RESP_OKAY 2'h0
`define SLCC_RESP_SLVERR 2'h2

`endif

// ---- dv/slcc_tx_model.sv ----
`timescale 1ns/1ps
module slcc_tx_model (
    // Clock and bench controls
    input wire clk,
    input wire [39:0] word,
    input wire err,
    input wire corrupt,
    // Lane and deframer outputs
    output logic [39:0] lane_data,
    output logic lane_bit_error,
    output logic sample_valid,
    output logic [15:0] sample_data,
    output logic [3:0] sample_index,
    output logic [1:0] sample_subchannel,
    output logic sample_link,
    output logic sample_q
);
    logic [8:0] cnt_r = 9'h000;
    logic [15:0] val;
    // Half the sweep is idle so the check has to skip unqualified samples
    assign val = {8'hC3 ^ cnt_r[7:0], cnt_r[7:0]} ^ {corrupt, 15'h0000};
    assign sample_valid = !cnt_r[8];
    assign sample_data = sample_valid ? val : ~val;
    assign {sample_q, sample_link, sample_subchannel, sample_index} = cnt_r[7:0];
    always @(posedge clk) begin
        cnt_r <= cnt_r + 9'h001;
        lane_data <= word;
        lane_bit_error <= err;
    end
endmodule

// ---- dv/slcc_top_sva.sv ----
`timescale 1ns/1ps
`include "slcc_defines.vh"
module slcc_top_sva (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Write channels
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp
);
    // Only the bus is visible here, so capture and check are judged by the bench
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("no write response");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address early");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_wready) else $error("data early");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read early");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `SLCC_RESP_SLVERR
        |-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
endmodule

// ---- dv/slcc_top_tb.sv ----
`timescale 1ns/1ps
module slcc_top_tb;
    logic clk, nrst, err, corrupt, irq, lane_bit_error, sample_valid, sample_link, sample_q;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lk, q, en, ex;
    logic [1:0] sample_subchannel, s_axi_bresp, s_axi_rresp, ch;
    logic [3:0] sample_index, s_axi_wstrb, sp;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [15:0] sample_data, rx, rf;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [39:0] word, lane_data, cw;
    logic [28:0] rows [6];
    logic [25:0] cases [6];
    integer bad_count = 0;
    integer checks = 0;
    slcc_tx_model u_slcc_tx_model (.clk, .word, .err, .corrupt, .lane_data, .lane_bit_error,
        .sample_valid, .sample_data, .sample_index, .sample_subchannel, .sample_link, .sample_q);
    slcc_top u_slcc_top (.clk, .nrst, .lane_data, .lane_bit_error, .sample_valid, .sample_data,
        .sample_index, .sample_subchannel, .sample_link, .sample_q, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input [9:0] i, input [7:0] d, input [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp("bresp", r, s_axi_bresp);
    endtask
    task automatic rd(input [9:0] i, input [7:0] e, input [1:0] r, input string nm);
        @(posedge clk);
        s_axi_araddr <= {i, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp(nm, {24'h00_0000, e}, s_axi_rdata);
        cmp("rresp", r, s_axi_rresp);
    endtask
    task automatic cap_chk(input [39:0] c);
        for (int k = 0; k < 5; k++) rd(10'h31F + 10'(k), c[8*k +: 8], 2'h0, "capture");
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #3000000;
        bad_count++;
        stop_test();
    end
    initial begin
        {nrst, err, corrupt, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
        {s_axi_arvalid, s_axi_rready, word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        rows = '{{1'b0, 10'h32C, 16'h0000, 2'h0}, {1'b0, 10'h323, 16'h0000, 2'h0},
            {1'b1, 10'h32D, 16'hA5A5, 2'h0}, {1'b1, 10'h32E, 16'h3C3C, 2'h0},
            {1'b1, 10'h32F, 16'hC1C0, 2'h0}, {1'b1, 10'h300, 16'h5500, 2'h2}};
        cases = '{{8'h00, 1'b1, 16'h0000, 1'b0}, {8'hFB, 1'b1, 16'h0000, 1'b0},
            {8'h54, 1'b1, 16'h0001, 1'b1}, {8'h9A, 1'b1, 16'h0100, 1'b1},
            {8'h38, 1'b0, 16'h0001, 1'b0}, {8'hA4, 1'b1, 16'h0000, 1'b0}};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[k]) begin
            if (rows[k][28]) wr(rows[k][27:18], rows[k][17:10], rows[k][1:0]);
            rd(rows[k][27:18], rows[k][9:2], rows[k][1:0], "row_read");
        end
        $display("register rows done");
        cw = 40'h12_3456_789A;
        word <= cw;
        wr(10'h31E, 8'h01, 2'h0);
        word <= 40'hFE_DCBA_9876;
        cap_chk(cw);
        cmp("irq", 0, irq);
        wr(10'h341, 8'h01, 2'h0);
        repeat (2) @(posedge clk);
        cmp("irq", 1, irq);
        wr(10'h340, 8'h01, 2'h0);
        repeat (2) @(posedge clk);
        cmp("irq", 0, irq);
        $display("request capture done");
        cw = 40'hA5_5A0F_F0C3;
        wr(10'h31E, 8'h02, 2'h0);
        {word, err} <= {cw, 1'b1};
        @(posedge clk);
        err <= 1'b0;
        @(posedge clk);
        word <= 40'h00_0000_0000;
        cap_chk(cw);
        $display("error capture done");
        foreach (cases[k]) begin
            {sp, ch, lk, q, en, rx, ex} = cases[k];
            rf = {8'hC3 ^ {q, lk, ch, sp}, q, lk, ch, sp} ^ rx;
            wr(10'h32F, {lk, q, 6'h00}, 2'h0);
            wr(10'h32E, rf[15:8], 2'h0);
            wr(10'h32D, rf[7:0], 2'h0);
            wr(10'h32C, {sp, ch, 2'b10}, 2'h0);
            wr(10'h32C, {sp, ch, 1'b0, en}, 2'h0);
            repeat (600) @(posedge clk);
            rd(10'h32F, {lk, q, 5'h00, ex}, 2'h0, "check_flag");
        end
        corrupt <= 1'b1;
        repeat (600) @(posedge clk);
        corrupt <= 1'b0;
        repeat (600) @(posedge clk);
        rd(10'h32F, {lk, q, 6'h01}, 2'h0, "sticky_flag");
        wr(10'h32C, {sp, ch, 2'b10}, 2'h0);
        rd(10'h32F, {lk, q, 6'h00}, 2'h0, "cleared_flag");
        $display("sample check done");
        rd(10'h340, 8'h03, 2'h0, "irq_status");
        rd(10'h341, 8'h01, 2'h0, "irq_mask");
        cmp("irq", 1, irq);
        $display("interrupt status done");
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        cmp("irq", 0, irq);
        rd(10'h31F, 8'h00, 2'h0, "reset_capture");
        rd(10'h32C, 8'h00, 2'h0, "reset_control");
        rd(10'h32D, 8'h00, 2'h0, "reset_reference");
        $display("mid-run reset done");
        stop_test();
    end
endmodule
bind slcc_top slcc_top_sva u_slcc_top_sva (.clk, .nrst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
